// file: rtl/serial_eeprom_framing.sv
// Two-wire serial EEPROM target: bus framing, standby and write window
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_framing #(
  parameter int unsigned WR_CYC = eeprom_link_pkg::WR_CYC_DEFAULT
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic LCLK,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic [2:0] CHIP_SELECT_STRAPS,
  input wire logic [7:0] TX_BYTE,
  output logic TX_TAKE,
  output logic [7:0] RX_BYTE,
  output logic RX_STROBE,
  output logic STANDBY,
  output logic WRITE_BUSY
);
  import eeprom_link_pkg::*;

  // ----------------------------------------------------------------
  // Link reset and pin conditioning
  // ----------------------------------------------------------------
  logic lrst1;
  logic link_rst;
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic [2:0] strap1;
  logic [2:0] straps;

  always_ff @(posedge LCLK) begin
    lrst1 <= RST;
    link_rst <= lrst1;
    strap1 <= CHIP_SELECT_STRAPS;
    straps <= strap1;
  end

  input_deglitch u_scl_filt (
    .clk(LCLK),
    .rst(link_rst),
    .din(SCL),
    .dout(scl_f)
  );

  input_deglitch u_sda_filt (
    .clk(LCLK),
    .rst(link_rst),
    .din(SDA_IN),
    .dout(sda_f)
  );

  always_ff @(posedge LCLK) begin
    if (link_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  // Data edges with the clock held high are framing, never data
  assign start_det = scl_f && scl_q && sda_q && !sda_f;
  assign stop_det = scl_f && scl_q && !sda_q && sda_f;

  // ----------------------------------------------------------------
  // Crossings between link and core
  // ----------------------------------------------------------------
  logic busy_l1;
  logic busy_l;
  logic wr_pend;
  logic wr_tog;
  logic gate;
  logic [2:0] tog_m;
  logic act_l;
  logic act_m1;
  logic act_m;
  logic timer_busy;
  link_state_t state;

  always_ff @(posedge LCLK) begin
    busy_l1 <= timer_busy;
    busy_l <= busy_l1;
    act_l <= (state != ST_IDLE) || wr_pend;
  end

  always_ff @(posedge MCLK) begin
    tog_m <= {tog_m[1:0], wr_tog};
    act_m1 <= act_l;
    act_m <= act_m1;
  end

  assign gate = wr_pend || busy_l;

  function automatic logic sel_match(input logic [7:0] b,
                                     input logic [2:0] s);
    sel_match = (b[7:4] == DEV_TYPE) && (b[3:1] == s);
  endfunction : sel_match

  // ----------------------------------------------------------------
  // Framing state machine
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic is_read;
  logic [1:0] wr_items;

  always_ff @(posedge LCLK) begin
    if (link_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      wr_items <= 2'h0;
      SDA_OE_N <= 1'b1;
      TX_TAKE <= 1'b0;
      RX_STROBE <= 1'b0;
      RX_BYTE <= 8'h00;
    end else begin
      TX_TAKE <= 1'b0;
      RX_STROBE <= 1'b0;
      if (gate) begin
        state <= ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (start_det) begin
        state <= ST_SEL;
        bit_cnt <= 4'h0;
        wr_items <= 2'h0;
        SDA_OE_N <= 1'b1;
      end else if (stop_det) begin
        state <= ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else begin
        case (state)
          ST_SEL, ST_WR: begin
            if (scl_rise && bit_cnt < BITS_PER_ITEM) begin
              shreg <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_PER_ITEM) begin
              bit_cnt <= 4'h0;
              if (state == ST_SEL) begin
                if (sel_match(shreg, straps)) begin
                  SDA_OE_N <= 1'b0;
                  is_read <= shreg[0];
                  state <= ST_SEL_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                SDA_OE_N <= 1'b0;
                RX_BYTE <= shreg;
                RX_STROBE <= 1'b1;
                if (wr_items != 2'h3) begin
                  wr_items <= wr_items + 2'h1;
                end
                state <= ST_WR_ACK;
              end
            end
          end
          ST_SEL_ACK: begin
            if (scl_fall) begin
              if (is_read) begin
                shreg <= TX_BYTE;
                SDA_OE_N <= TX_BYTE[7];
                TX_TAKE <= 1'b1;
                bit_cnt <= 4'h1;
                state <= ST_RD;
              end else begin
                SDA_OE_N <= 1'b1;
                state <= ST_WR;
              end
            end
          end
          ST_WR_ACK: begin
            if (scl_fall) begin
              SDA_OE_N <= 1'b1;
              state <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt == BITS_PER_ITEM) begin
                SDA_OE_N <= 1'b1;
                bit_cnt <= 4'h0;
                state <= ST_RD_ACK;
              end else begin
                SDA_OE_N <= shreg[6];
                shreg <= {shreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RD_ACK: begin
            // Controller acknowledge continues the read, else return to idle
            if (scl_rise) begin
              state <= sda_f ? ST_IDLE : ST_SEL_ACK;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge LCLK) begin
    if (link_rst) begin
      SDA_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write window request and standby
  // ----------------------------------------------------------------
  logic wr_stop;

  assign wr_stop = stop_det && !gate && wr_items >= WR_ITEMS_MIN &&
                   (state == ST_WR || state == ST_WR_ACK);

  always_ff @(posedge LCLK) begin
    if (link_rst) begin
      wr_tog <= 1'b0;
      wr_pend <= 1'b0;
    end else if (wr_stop) begin
      wr_tog <= !wr_tog;
      wr_pend <= 1'b1;
    end else if (busy_l) begin
      wr_pend <= 1'b0;
    end
  end

  write_cycle_timer #(
    .WR_CYC(WR_CYC)
  ) u_timer (
    .clk(MCLK),
    .rst(RST),
    .start(tog_m[2] ^ tog_m[1]),
    .busy(timer_busy)
  );

  assign WRITE_BUSY = timer_busy;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      STANDBY <= 1'b1;
    end else begin
      STANDBY <= !act_m && !timer_busy;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_start_restart: assert property (@(posedge LCLK)
    disable iff (link_rst)
    start_det && !gate |=> state == ST_SEL && bit_cnt == 4'h0)
    else $error("start did not restart select reception");

  a_stop_idle: assert property (@(posedge LCLK)
    disable iff (link_rst)
    stop_det |=> state == ST_IDLE && SDA_OE_N)
    else $error("stop did not end the transfer");

  a_sda_clock_low: assert property (@(posedge LCLK)
    disable iff (link_rst)
    $changed(SDA_OE_N) && !$past(stop_det) && !$past(start_det) &&
    !$past(gate) |-> !scl_f)
    else $error("data line driven while clock high");

  a_busy_no_ack: assert property (@(posedge LCLK)
    disable iff (link_rst)
    gate |=> SDA_OE_N && state == ST_IDLE)
    else $error("device answered during write cycle");

  a_select_ack: assert property (@(posedge LCLK)
    disable iff (link_rst)
    state == ST_SEL && scl_fall && bit_cnt == BITS_PER_ITEM &&
    sel_match(shreg, straps) && !gate && !start_det && !stop_det
    |=> !SDA_OE_N && state == ST_SEL_ACK)
    else $error("matching select byte not acknowledged");

  a_select_miss: assert property (@(posedge LCLK)
    disable iff (link_rst)
    state == ST_SEL && scl_fall && bit_cnt == BITS_PER_ITEM &&
    !sel_match(shreg, straps) && !gate && !start_det && !stop_det
    |=> SDA_OE_N && state == ST_IDLE)
    else $error("mismatched select byte not ignored");

  a_write_request: assert property (@(posedge LCLK)
    disable iff (link_rst)
    wr_stop |=> wr_tog != $past(wr_tog) && wr_pend)
    else $error("write stop did not request write cycle");

  a_standby_reset: assert property (@(posedge MCLK)
    RST |=> STANDBY)
    else $error("standby not entered at reset");

endmodule : serial_eeprom_framing
`default_nettype wire

// file: rtl/eeprom_link_pkg.sv
// Constants and types shared by the serial EEPROM bus framing design
package eeprom_link_pkg;

  // ----------------------------------------------------------------
  // Clocks and timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_PS = 4000;
  localparam int LCLK_PERIOD_PS = 12000;
  localparam int GLITCH_TIME_NS = 50;
  localparam int WR_TIME_MS = 5;
  // More samples than any pulse below the suppression time can give
  localparam int GLITCH_CYC_I =
    (GLITCH_TIME_NS * 1000 - 1) / LCLK_PERIOD_PS + 2;
  localparam logic [2:0] GLITCH_CYC = 3'(GLITCH_CYC_I);
  // Longest write time, rounded down
  localparam int unsigned WR_CYC_DEFAULT =
    (WR_TIME_MS * 1000000) / (MCLK_PERIOD_PS / 1000);

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_ITEM = 4'h8;
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [1:0] WR_ITEMS_MIN = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_SEL_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } link_state_t;

endpackage : eeprom_link_pkg

// file: rtl/input_deglitch.sv
// Two-stage synchroniser followed by a stability filter for one pin
`timescale 1ns/1ps
`default_nettype none
module input_deglitch (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  import eeprom_link_pkg::*;

  logic sync1;
  logic sync2;
  logic [2:0] cnt;

  always_ff @(posedge clk) begin
    sync1 <= din;
    sync2 <= sync1;
  end

  // Count cycles the synchronised level differs from the output
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 3'h0;
    end else if (sync2 == dout || cnt == GLITCH_CYC - 3'h1) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= 1'b1;
    end else if (sync2 != dout && cnt == GLITCH_CYC - 3'h1) begin
      dout <= sync2;
    end
  end

  a_filter_hold: assert property (@(posedge clk) disable iff (rst)
    $changed(dout) |-> $past(cnt) == GLITCH_CYC - 3'h1)
    else $error("filtered pin changed before hold time");

endmodule : input_deglitch
`default_nettype wire

// file: rtl/write_cycle_timer.sv
// Self-timed nonvolatile write window
`timescale 1ns/1ps
`default_nettype none
module write_cycle_timer #(
  parameter int unsigned WR_CYC = eeprom_link_pkg::WR_CYC_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  import eeprom_link_pkg::*;

  localparam int CW = $clog2(WR_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(WR_CYC - 1);

  logic [CW-1:0] cnt;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= '0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      cnt <= '0;
    end else if (busy) begin
      if (cnt == LAST) begin
        busy <= 1'b0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  a_busy_start: assert property (@(posedge clk) disable iff (rst)
    start && !busy |=> busy && cnt == '0)
    else $error("write window did not open on request");

  a_busy_length: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) |-> $past(cnt) == LAST)
    else $error("write window closed at wrong count");

endmodule : write_cycle_timer
`default_nettype wire

// file: testbench/bus_ctrl.sv
// Two-wire bus controller model that drives the serial clock and data
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // Low 1.8 us, high 0.7 us; an optional 36 ns glitch on both lines
  task automatic bit_xfer(input logic b, input logic g, output logic r);
    sda_drv <= b;
    hold(350);
    scl <= 1'b1;
    hold(80);
    if (g) begin
      scl <= 1'b0;
      sda_drv <= 1'b0;
      hold(9);
      scl <= 1'b1;
      sda_drv <= b;
    end
    hold(10);
    r = sda;
    hold(85);
    scl <= 1'b0;
    hold(100);
  endtask : bit_xfer

  task automatic start_cond;
    sda_drv <= 1'b1;
    hold(100);
    scl <= 1'b1;
    hold(200);
    sda_drv <= 1'b0;
    hold(200);
    scl <= 1'b0;
    hold(100);
  endtask : start_cond

  task automatic stop_cond;
    sda_drv <= 1'b0;
    hold(225);
    scl <= 1'b1;
    hold(200);
    sda_drv <= 1'b1;
    hold(200);
  endtask : stop_cond

  task automatic put_byte(input logic [7:0] d, input logic g,
                          output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], g && i == 3, r);
    end
    bit_xfer(1'b1, 1'b0, ack);
  endtask : put_byte

  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, 1'b0, d[i]);
    end
    bit_xfer(nack, 1'b0, r);
  endtask : get_byte

  // Clock until the data line is seen high, at most nine times, then start
  task automatic recover(output int n);
    logic r;
    n = 0;
    r = 1'b0;
    while (r !== 1'b1 && n < 9) begin
      n++;
      bit_xfer(1'b1, 1'b0, r);
    end
    start_cond();
  endtask : recover
endmodule : bus_ctrl
`default_nettype wire

// file: testbench/serial_eeprom_framing_bench.sv
// Self-checking bench for the serial EEPROM bus framing block
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_framing_bench;
  localparam int unsigned WR_CYC = 7000;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam logic [7:0] SEL_W = {4'hA, STRAPS, 1'b0};
  logic MCLK = 1'b0;
  logic RST, LCLK, SCL, SDA_IN, SDA_OUT, SDA_OE_N;
  logic TX_TAKE, RX_STROBE, STANDBY, WRITE_BUSY, sda_drv, ack;
  logic [7:0] TX_BYTE, RX_BYTE, rx_got, d;
  // Read data in take order: two for the read test, one for recovery
  logic [7:0] tx_tab [4] = '{8'hA5, 8'h87, 8'h87, 8'h00};
  int tx_n, rx_cnt, busy_cyc, fail_count, cmp_count, n, busy0;

  // ----------------------------------------------------------------
  // Clocks, wiring and far-side data
  // ----------------------------------------------------------------
  always #2 MCLK = ~MCLK;
  initial begin
    LCLK = 1'b0;
    #1.3;
    forever #6 LCLK = ~LCLK;
  end
  // Open-drain wire with pull-up
  assign SDA_IN = sda_drv & (SDA_OE_N | SDA_OUT);

  always @(posedge LCLK) begin
    if (TX_TAKE)
      tx_n <= tx_n + 1;
    TX_BYTE <= tx_tab[tx_n[1:0]];
    if (RX_STROBE) begin
      rx_cnt <= rx_cnt + 1;
      rx_got <= RX_BYTE;
    end
  end
  always @(posedge MCLK) begin
    if (WRITE_BUSY === 1'b1)
      busy_cyc <= busy_cyc + 1;
  end

  serial_eeprom_framing #(.WR_CYC(WR_CYC)) serial_eeprom_framing_i (
    .MCLK(MCLK), .RST(RST), .LCLK(LCLK), .SCL(SCL), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .CHIP_SELECT_STRAPS(STRAPS),
    .TX_BYTE(TX_BYTE), .TX_TAKE(TX_TAKE), .RX_BYTE(RX_BYTE),
    .RX_STROBE(RX_STROBE), .STANDBY(STANDBY), .WRITE_BUSY(WRITE_BUSY)
  );
  bus_ctrl bus_ctrl_i (.clk(MCLK), .sda(SDA_IN), .scl(SCL),
    .sda_drv(sda_drv));

  // ----------------------------------------------------------------
  // Checks and scenarios
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic send(input logic [7:0] v, input logic exp_ack);
    bus_ctrl_i.put_byte(v, 1'b0, ack);
    chk(ack, exp_ack);
  endtask : send

  task automatic t_reset;
    chk(STANDBY, 1'b1);
    chk(WRITE_BUSY, 1'b0);
    chk({SDA_OE_N, SDA_OUT}, 2'h2);
    $display("reset test done");
  endtask : t_reset

  task automatic t_write;
    busy0 = busy_cyc;
    n = rx_cnt;
    bus_ctrl_i.start_cond();
    send(SEL_W, 1'b0);
    chk(STANDBY, 1'b0);
    send(8'h21, 1'b0);
    chk(rx_got, 8'h21);
    send(8'hC3, 1'b0);
    chk(rx_got, 8'hC3);
    chk(rx_cnt - n, 2);
    bus_ctrl_i.stop_cond();
    chk(WRITE_BUSY, 1'b1);
    bus_ctrl_i.start_cond();
    send(SEL_W, 1'b1);
    bus_ctrl_i.stop_cond();
    for (int i = 0; i < WR_CYC && WRITE_BUSY === 1'b1; i++) begin
      @(posedge MCLK);
    end
    repeat (10) @(posedge MCLK);
    chk(busy_cyc - busy0, WR_CYC);
    chk(STANDBY, 1'b1);
    $display("write test done");
  endtask : t_write

  task automatic t_select;
    bus_ctrl_i.start_cond();
    send({4'hA, ~STRAPS, 1'b0}, 1'b1);
    chk(STANDBY, 1'b1);
    bus_ctrl_i.start_cond();
    send({4'h5, STRAPS, 1'b0}, 1'b1);
    bus_ctrl_i.stop_cond();
    $display("select test done");
  endtask : t_select

  task automatic t_read;
    bus_ctrl_i.start_cond();
    send(SEL_W | 8'h01, 1'b0);
    chk(STANDBY, 1'b0);
    bus_ctrl_i.get_byte(1'b0, d);
    chk(d, 8'hA5);
    bus_ctrl_i.get_byte(1'b1, d);
    chk(d, 8'h87);
    bus_ctrl_i.stop_cond();
    repeat (20) @(posedge MCLK);
    chk(STANDBY, 1'b1);
    $display("read test done");
  endtask : t_read

  task automatic t_restart;
    n = rx_cnt;
    bus_ctrl_i.start_cond();
    send(SEL_W, 1'b0);
    for (int i = 0; i < 3; i++) begin
      bus_ctrl_i.bit_xfer(1'b1, 1'b0, ack);
    end
    bus_ctrl_i.start_cond();
    send(SEL_W, 1'b0);
    bus_ctrl_i.put_byte(8'h9E, 1'b1, ack);
    chk(ack, 1'b0);
    chk(rx_got, 8'h9E);
    chk(rx_cnt - n, 1);
    bus_ctrl_i.stop_cond();
    chk(WRITE_BUSY, 1'b0);
    $display("restart test done");
  endtask : t_restart

  task automatic t_recover;
    bus_ctrl_i.start_cond();
    send(SEL_W | 8'h01, 1'b0);
    bus_ctrl_i.bit_xfer(1'b1, 1'b0, ack);
    bus_ctrl_i.bit_xfer(1'b1, 1'b0, ack);
    bus_ctrl_i.recover(n);
    chk(n, 4);
    send(SEL_W, 1'b0);
    bus_ctrl_i.stop_cond();
    $display("recovery test done");
  endtask : t_recover

  initial begin
    RST = 1'b1;
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    repeat (60) @(posedge MCLK);
    t_reset();
    t_write();
    t_select();
    t_read();
    t_restart();
    t_recover();
    results();
  end

  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule : serial_eeprom_framing_bench
`default_nettype wire
